// ==== verilog/adcr_cfg.svh ====
// offsets, field positions, reset values and coefficient codes of the angle dsp register bank
`ifndef ADCR_CFG_SVH
`define ADCR_CFG_SVH
`define ADCR_IDX_COEF2   6'h20
`define ADCR_IDX_COEF3   6'h21
`define ADCR_IDX_AKV_HI  6'h22
`define ADCR_IDX_AKV_LO  6'h23
`define ADCR_IDX_DKV_HI  6'h26
`define ADCR_IDX_DKV_LO  6'h27
`define ADCR_IDX_LPF     6'h2A
`define ADCR_IDX_CTRL    6'h2B
`define ADCR_IDX_STATUS  6'h2C
`define ADCR_RST_VAL     16'h0000
`define ADCR_MASK_FULL   16'hFFFF
`define ADCR_MASK_KV_HI  16'h00FF
`define ADCR_MASK_LPF    16'h003C
`define ADCR_MASK_CTRL   16'h0037
`define ADCR_Q_FRAC      14
`define ADCR_LPF_ANG_LSB 4
`define ADCR_LPF_VEL_LSB 2
`define ADCR_MUX_LSB     4
`define ADCR_DIR_BIT     2
`define ADCR_SKIP_CAL    1
`define ADCR_SKIP_COIL   0
`define ADCR_LPF_K16     8'h10
`define ADCR_LPF_K32     8'h20
`define ADCR_LPF_K64     8'h40
`define ADCR_LPF_K128    8'h80
`define ADCR_SH_K16      3'h4
`define ADCR_SH_K32      3'h5
`define ADCR_SH_K64      3'h6
`define ADCR_SH_K128     3'h7
`endif

// ==== verilog/adcr_pkg.sv ====
// types shared by the angle dsp register bank
package adcr_pkg;
   typedef struct packed {
      logic        read;
      logic        write;
      logic [7:0]  address;
      logic [3:0]  byteenable;
      logic [31:0] writedata;
   } adcr_avs_req_type;

   typedef enum logic [1:0] {
      ANG_DELAY_A = 2'b00,
      ANG_DELAY_B = 2'b01,
      ANG_LPF     = 2'b10,
      ANG_ABS     = 2'b11
   } adcr_ang_src_type;

   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_ADC_CAL = 2'b01,
      ST_COIL    = 2'b11,
      ST_DONE    = 2'b10
   } adcr_start_state_type;

   typedef struct packed {
      logic [15:0]      coef2;
      logic [15:0]      coef3;
      logic [23:0]      abs_kv;
      logic [23:0]      delay_kv;
      logic [7:0]       ang_k;
      logic [7:0]       vel_k;
      adcr_ang_src_type ang_src;
      logic             cal_dir;
      logic             skip_cal;
      logic             skip_coil;
   } adcr_cfg_type;
endpackage

// ==== verilog/adcr_regs.sv ====
// angle dsp configuration register bank with the datapath taps that it steers
// Function
// - each fine clarke real coefficient is read as signed Q2.14.
// - the coefficient at 0x20 weights filter output 2 and the one at 0x21 weights filter output 3.
// - the absolute velocity coefficient is the low byte of 0x22 above the 16 bits of 0x23.
// - the absolute velocity coefficient multiplies the velocity term of the absolute extrapolation.
// - the delay velocity coefficient is the low byte of 0x26 above the 16 bits of 0x27.
// - the delay velocity coefficient weights the velocity part of the delay extrapolator.
// - the low-pass tuned by 0x2A filters the digitized receiver samples.
// - bits 5:4 of 0x2A pick angle low-pass coefficient 16, 32, 64 or 128.
// - bits 3:2 of 0x2A pick velocity low-pass coefficient 16, 32, 64 or 128.
// - control bits 5:4 pick delay angle for 00 or 01, low-pass angle for 10, absolute angle for 11.
// - control bit 2 makes calibration count up clockwise when 0 and counter-clockwise when 1.
// - control bit 1 set skips the converter calibration at startup.
// - control bit 0 set skips the open-coil check at startup.
// - all bank registers are zero after reset.
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "adcr_cfg.svh"

module adcr_regs #(
   parameter int ANG_W = 24,
   parameter int SMP_W = 16
) (
   input  wire logic                       MCLK_I,
   input  wire logic                       SYS_RST_I,
   input  wire adcr_pkg::adcr_avs_req_type AVS_REQ_I,
   output logic [31:0]                     AVS_READDATA_O,
   output logic                            AVS_WAITREQUEST_O,
   output adcr_pkg::adcr_cfg_type          CFG_O,
   input  wire logic signed [15:0]         FINE_FILT2_I,
   input  wire logic signed [15:0]         FINE_FILT3_I,
   output logic signed [18:0]              CLARKE_RE_O,
   input  wire logic signed [15:0]         VELOCITY_I,
   input  wire logic                       VEL_VALID_I,
   output logic signed [40:0]              ABS_VEL_TERM_O,
   output logic signed [40:0]              DELAY_VEL_TERM_O,
   input  wire logic signed [SMP_W-1:0]    RX_SAMPLE_I,
   input  wire logic                       RX_SAMPLE_VALID_I,
   output logic signed [SMP_W-1:0]         RX_LPF_O,
   output logic signed [SMP_W-1:0]         VEL_LPF_O,
   input  wire logic [ANG_W-1:0]           ANGLE_DELAY_I,
   input  wire logic [ANG_W-1:0]           ANGLE_LPF_I,
   input  wire logic [ANG_W-1:0]           ANGLE_ABS_I,
   output logic [ANG_W-1:0]                ANGLE_O,
   input  wire logic                       POR_START_I,
   input  wire logic                       ADC_CAL_DONE_I,
   input  wire logic                       COIL_CHECK_DONE_I,
   output logic                            ADC_CAL_RUN_O,
   output logic                            COIL_CHECK_RUN_O,
   output logic                            STARTUP_DONE_O
);

   localparam int NREG  = 8;
   localparam int R_C2  = 0;
   localparam int R_C3  = 1;
   localparam int R_AKH = 2;
   localparam int R_AKL = 3;
   localparam int R_DKH = 4;
   localparam int R_DKL = 5;
   localparam int R_LPF = 6;
   localparam int R_CTL = 7;
   localparam int ACC_W = SMP_W + 8;

   localparam logic [5:0] REG_IDX [NREG] = '{
      `ADCR_IDX_COEF2, `ADCR_IDX_COEF3, `ADCR_IDX_AKV_HI, `ADCR_IDX_AKV_LO,
      `ADCR_IDX_DKV_HI, `ADCR_IDX_DKV_LO, `ADCR_IDX_LPF, `ADCR_IDX_CTRL};
   localparam logic [15:0] REG_MASK [NREG] = '{
      `ADCR_MASK_FULL, `ADCR_MASK_FULL, `ADCR_MASK_KV_HI, `ADCR_MASK_FULL,
      `ADCR_MASK_KV_HI, `ADCR_MASK_FULL, `ADCR_MASK_LPF, `ADCR_MASK_CTRL};

   function automatic logic [7:0] lpf_coef(input logic [1:0] sel);
      case (sel)
         2'b00:   lpf_coef = `ADCR_LPF_K16;
         2'b01:   lpf_coef = `ADCR_LPF_K32;
         2'b10:   lpf_coef = `ADCR_LPF_K64;
         default: lpf_coef = `ADCR_LPF_K128;
      endcase
   endfunction

   function automatic logic [2:0] lpf_shift(input logic [1:0] sel);
      case (sel)
         2'b00:   lpf_shift = `ADCR_SH_K16;
         2'b01:   lpf_shift = `ADCR_SH_K32;
         2'b10:   lpf_shift = `ADCR_SH_K64;
         default: lpf_shift = `ADCR_SH_K128;
      endcase
   endfunction

   // ---- avalon slave: one wait state on every access
   logic                                ack;
   logic                                next_ack;
   logic [31:0]                         rdata;
   logic [31:0]                         next_rdata;
   logic                                req;
   logic                                wr_commit;
   logic [5:0]                          acc_idx;
   logic [15:0]                         rd_val;
   logic [15:0]                         status;
   logic [15:0]                         regs [NREG];
   adcr_pkg::adcr_start_state_type      st;
   adcr_pkg::adcr_start_state_type      next_st;

   assign req               = AVS_REQ_I.read | AVS_REQ_I.write;
   assign acc_idx           = AVS_REQ_I.address[7:2];
   assign AVS_WAITREQUEST_O = req & ~ack;
   // a write lands only on the edge where waitrequest is seen low
   assign wr_commit         = AVS_REQ_I.write & ack;
   assign AVS_READDATA_O    = rdata;
   assign status            = {13'h0000, STARTUP_DONE_O, st};

   always_comb begin
      next_ack = req & ~ack;
   end

   always_comb begin
      rd_val = 16'h0000;
      for (int i = 0; i < NREG; i++) begin
         if (acc_idx == REG_IDX[i]) begin
            rd_val = regs[i];
         end
      end
      if (acc_idx == `ADCR_IDX_STATUS) begin
         rd_val = status;
      end
   end

   always_comb begin
      next_rdata = rdata;
      if (AVS_REQ_I.read && !ack) begin
         next_rdata = {16'h0000, rd_val};
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         ack   <= 1'b0;
         rdata <= 32'h0000_0000;
      end else begin
         ack   <= next_ack;
         rdata <= next_rdata;
      end
   end

   // ---- register file, reserved bits masked on write
   for (genvar g = 0; g < NREG; g++) begin : g_reg
      logic [15:0] q;
      logic [15:0] next_q;

      always_comb begin
         next_q = q;
         if (wr_commit && (acc_idx == REG_IDX[g])) begin
            if (AVS_REQ_I.byteenable[0]) begin
               next_q[7:0] = AVS_REQ_I.writedata[7:0];
            end
            if (AVS_REQ_I.byteenable[1]) begin
               next_q[15:8] = AVS_REQ_I.writedata[15:8];
            end
            next_q = next_q & REG_MASK[g];
         end
      end

      always_ff @(posedge MCLK_I) begin
         if (SYS_RST_I) begin
            q <= `ADCR_RST_VAL;
         end else begin
            q <= next_q;
         end
      end

      assign regs[g] = q;
   end

   // ---- decoded configuration
   always_comb begin
      CFG_O.coef2     = regs[R_C2];
      CFG_O.coef3     = regs[R_C3];
      CFG_O.abs_kv    = {regs[R_AKH][7:0], regs[R_AKL]};
      CFG_O.delay_kv  = {regs[R_DKH][7:0], regs[R_DKL]};
      CFG_O.ang_k     = lpf_coef(regs[R_LPF][`ADCR_LPF_ANG_LSB+:2]);
      CFG_O.vel_k     = lpf_coef(regs[R_LPF][`ADCR_LPF_VEL_LSB+:2]);
      CFG_O.ang_src   = adcr_pkg::adcr_ang_src_type'(regs[R_CTL][`ADCR_MUX_LSB+:2]);
      // the calibration routine reads this level to pick its count direction
      CFG_O.cal_dir   = regs[R_CTL][`ADCR_DIR_BIT];
      CFG_O.skip_cal  = regs[R_CTL][`ADCR_SKIP_CAL];
      CFG_O.skip_coil = regs[R_CTL][`ADCR_SKIP_COIL];
   end

   // ---- clarke real part and velocity terms
   logic signed [31:0] prod2;
   logic signed [31:0] prod3;
   logic signed [32:0] csum;
   logic signed [32:0] cshift;
   logic signed [18:0] next_clarke;
   logic signed [40:0] next_abs_term;
   logic signed [40:0] next_dly_term;

   always_comb begin
      prod2         = FINE_FILT2_I * $signed(CFG_O.coef2);
      prod3         = FINE_FILT3_I * $signed(CFG_O.coef3);
      csum          = 33'(prod2) + 33'(prod3);
      cshift        = csum >>> `ADCR_Q_FRAC;
      next_clarke   = cshift[18:0];
      next_abs_term = $signed({1'b0, CFG_O.abs_kv}) * VELOCITY_I;
      next_dly_term = $signed({1'b0, CFG_O.delay_kv}) * VELOCITY_I;
   end

   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         CLARKE_RE_O      <= 19'sh00000;
         ABS_VEL_TERM_O   <= 41'sh0;
         DELAY_VEL_TERM_O <= 41'sh0;
      end else begin
         CLARKE_RE_O      <= next_clarke;
         ABS_VEL_TERM_O   <= next_abs_term;
         DELAY_VEL_TERM_O <= next_dly_term;
      end
   end

   // ---- first-order low-pass: acc += (x - acc) / k, k a power of two
   // eight guard bits keep small steps from vanishing at k = 128
   logic signed [SMP_W-1:0] lp_in  [2];
   logic                    lp_en  [2];
   logic [2:0]              lp_sh  [2];
   logic signed [SMP_W-1:0] lp_out [2];

   assign lp_in[0] = RX_SAMPLE_I;
   assign lp_in[1] = VELOCITY_I;
   assign lp_en[0] = RX_SAMPLE_VALID_I;
   assign lp_en[1] = VEL_VALID_I;
   assign lp_sh[0] = lpf_shift(regs[R_LPF][`ADCR_LPF_ANG_LSB+:2]);
   assign lp_sh[1] = lpf_shift(regs[R_LPF][`ADCR_LPF_VEL_LSB+:2]);

   for (genvar f = 0; f < 2; f++) begin : g_lpf
      logic signed [ACC_W-1:0] acc;
      logic signed [ACC_W-1:0] next_acc;
      logic signed [ACC_W:0]   diff;
      logic signed [ACC_W:0]   step;

      always_comb begin
         diff     = (ACC_W+1)'($signed({lp_in[f], 8'h00})) - (ACC_W+1)'(acc);
         step     = diff >>> lp_sh[f];
         next_acc = acc;
         if (lp_en[f]) begin
            next_acc = acc + step[ACC_W-1:0];
         end
      end

      always_ff @(posedge MCLK_I) begin
         if (SYS_RST_I) begin
            acc <= '0;
         end else begin
            acc <= next_acc;
         end
      end

      assign lp_out[f] = acc[ACC_W-1 -: SMP_W];
   end

   assign RX_LPF_O  = lp_out[0];
   assign VEL_LPF_O = lp_out[1];

   // ---- angle output source
   logic [ANG_W-1:0] next_angle;

   always_comb begin
      case (CFG_O.ang_src)
         adcr_pkg::ANG_LPF: next_angle = ANGLE_LPF_I;
         adcr_pkg::ANG_ABS: next_angle = ANGLE_ABS_I;
         default:           next_angle = ANGLE_DELAY_I;
      endcase
   end

   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         ANGLE_O <= '0;
      end else begin
         ANGLE_O <= next_angle;
      end
   end

   // ---- startup sequencer; skip bits are sampled when a step would begin,
   // so firmware must set them before raising the start request
   always_comb begin
      next_st = st;
      case (st)
         adcr_pkg::ST_IDLE: begin
            if (POR_START_I) begin
               if (!CFG_O.skip_cal) begin
                  next_st = adcr_pkg::ST_ADC_CAL;
               end else if (!CFG_O.skip_coil) begin
                  next_st = adcr_pkg::ST_COIL;
               end else begin
                  next_st = adcr_pkg::ST_DONE;
               end
            end
         end
         adcr_pkg::ST_ADC_CAL: begin
            if (ADC_CAL_DONE_I) begin
               next_st = CFG_O.skip_coil ? adcr_pkg::ST_DONE : adcr_pkg::ST_COIL;
            end
         end
         adcr_pkg::ST_COIL: begin
            if (COIL_CHECK_DONE_I) begin
               next_st = adcr_pkg::ST_DONE;
            end
         end
         adcr_pkg::ST_DONE: next_st = adcr_pkg::ST_DONE;
         default:           next_st = adcr_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         st <= adcr_pkg::ST_IDLE;
      end else begin
         st <= next_st;
      end
   end

   assign ADC_CAL_RUN_O    = (st == adcr_pkg::ST_ADC_CAL);
   assign COIL_CHECK_RUN_O = (st == adcr_pkg::ST_COIL);
   assign STARTUP_DONE_O   = (st == adcr_pkg::ST_DONE);

   // ---- checks
   default clocking cb @(posedge MCLK_I);
   endclocking
   default disable iff (SYS_RST_I);

   a_clarke_unity: assert property (
      (CFG_O.coef2 == 16'h4000 && CFG_O.coef3 == 16'h0000)
      |=> CLARKE_RE_O == 19'($past(FINE_FILT2_I)))
      else $error("clarke unity gain on output 2 wrong");

   a_clarke_neg3: assert property (
      (CFG_O.coef2 == 16'h0000 && CFG_O.coef3 == 16'hC000)
      |=> CLARKE_RE_O == -19'($past(FINE_FILT3_I)))
      else $error("clarke minus one on output 3 wrong");

   a_abs_kv_high: assert property (
      (wr_commit && acc_idx == `ADCR_IDX_AKV_HI && AVS_REQ_I.byteenable[0])
      |=> CFG_O.abs_kv[23:16] == $past(AVS_REQ_I.writedata[7:0]))
      else $error("absolute coefficient high byte not taken");

   a_abs_term: assert property (
      (VELOCITY_I == 16'sh0001) |=> ABS_VEL_TERM_O == 41'($past({1'b0, CFG_O.abs_kv})))
      else $error("absolute velocity term wrong");

   a_dly_kv_low: assert property (
      (wr_commit && acc_idx == `ADCR_IDX_DKV_LO && AVS_REQ_I.byteenable == 4'h3)
      |=> CFG_O.delay_kv[15:0] == $past(AVS_REQ_I.writedata[15:0]))
      else $error("delay coefficient low part not taken");

   a_dly_term: assert property (
      (VELOCITY_I == -16'sh0001) |=> DELAY_VEL_TERM_O == -41'($past({1'b0, CFG_O.delay_kv})))
      else $error("delay velocity term wrong");

   a_lpf_hold: assert property (
      !RX_SAMPLE_VALID_I |=> $stable(RX_LPF_O))
      else $error("receiver low-pass moved without a sample");

   a_ang_coef: assert property (
      (wr_commit && acc_idx == `ADCR_IDX_LPF && AVS_REQ_I.byteenable[0])
      |=> CFG_O.ang_k == (`ADCR_LPF_K16 << $past(AVS_REQ_I.writedata[5:4])))
      else $error("angle low-pass coefficient wrong");

   a_vel_coef: assert property (
      (wr_commit && acc_idx == `ADCR_IDX_LPF && AVS_REQ_I.byteenable[0])
      |=> CFG_O.vel_k == (`ADCR_LPF_K16 << $past(AVS_REQ_I.writedata[3:2])))
      else $error("velocity low-pass coefficient wrong");

   a_ang_mux_abs: assert property (
      (regs[R_CTL][5:4] == 2'b11) |=> ANGLE_O == $past(ANGLE_ABS_I))
      else $error("absolute angle not selected");

   a_ang_mux_dly: assert property (
      (regs[R_CTL][5] == 1'b0) |=> ANGLE_O == $past(ANGLE_DELAY_I))
      else $error("delay angle not selected");

   a_cal_dir: assert property (
      (wr_commit && acc_idx == `ADCR_IDX_CTRL && AVS_REQ_I.byteenable[0])
      |=> CFG_O.cal_dir == $past(AVS_REQ_I.writedata[2]))
      else $error("turn direction not taken");

   a_skip_cal: assert property (
      (st == adcr_pkg::ST_IDLE && POR_START_I && CFG_O.skip_cal) |=> !ADC_CAL_RUN_O)
      else $error("converter calibration ran while skipped");

   a_skip_coil: assert property (
      (ADC_CAL_RUN_O && ADC_CAL_DONE_I && CFG_O.skip_coil) |=> STARTUP_DONE_O && !COIL_CHECK_RUN_O)
      else $error("coil check ran while skipped");

   a_reset_zero: assert property (
      $fell(SYS_RST_I) |-> (CFG_O.ang_k == `ADCR_LPF_K16 && CFG_O.ang_src == adcr_pkg::ANG_DELAY_A
                            && CFG_O.abs_kv == 24'h000000 && CFG_O.coef2 == 16'h0000))
      else $error("bank not cleared by reset");

   a_resv_zero: assert property (
      (AVS_REQ_I.read && ack && acc_idx == `ADCR_IDX_LPF)
      |-> (AVS_READDATA_O[31:6] == 26'h0 && AVS_READDATA_O[1:0] == 2'h0))
      else $error("reserved bits read nonzero");

   c_write_ctrl:  cover property (wr_commit && acc_idx == `ADCR_IDX_CTRL);
   c_read_status: cover property (AVS_REQ_I.read && ack && acc_idx == `ADCR_IDX_STATUS);
   c_full_start:  cover property (COIL_CHECK_RUN_O ##1 STARTUP_DONE_O);
   c_skip_both:   cover property (st == adcr_pkg::ST_IDLE ##1 STARTUP_DONE_O);

endmodule // adcr_regs

// ==== testbench/tb.sv ====
// self-checking bench for the angle dsp configuration register bank
`timescale 1ns/1ps
`include "adcr_cfg.svh"
module tb;
   logic                       mclk, rst;
   adcr_pkg::adcr_avs_req_type req;
   logic [31:0]                rdata;
   logic                       wreq;
   adcr_pkg::adcr_cfg_type     cfg;
   logic signed [15:0]         f2, f3, vel, rx, rx_lpf, vel_lpf;
   logic signed [18:0]         clk_re;
   logic signed [40:0]         akv_t, dkv_t;
   logic [23:0]                a_d, a_l, a_a, ang;
   logic                       vel_v, rx_v, por, cal_dn, coil_dn, cal_run, coil_run, st_dn;
   logic [15:0]                regs [64];
   logic [31:0]                exp_q [$];
   logic signed [23:0]         rx_acc, vel_acc;
   int                         num_errors, n_tests;

   adcr_regs i_dut (.MCLK_I(mclk), .SYS_RST_I(rst), .AVS_REQ_I(req), .AVS_READDATA_O(rdata),
      .AVS_WAITREQUEST_O(wreq), .CFG_O(cfg), .FINE_FILT2_I(f2), .FINE_FILT3_I(f3), .CLARKE_RE_O(clk_re),
      .VELOCITY_I(vel), .VEL_VALID_I(vel_v), .ABS_VEL_TERM_O(akv_t), .DELAY_VEL_TERM_O(dkv_t),
      .RX_SAMPLE_I(rx), .RX_SAMPLE_VALID_I(rx_v), .RX_LPF_O(rx_lpf), .VEL_LPF_O(vel_lpf),
      .ANGLE_DELAY_I(a_d), .ANGLE_LPF_I(a_l), .ANGLE_ABS_I(a_a), .ANGLE_O(ang), .POR_START_I(por),
      .ADC_CAL_DONE_I(cal_dn), .COIL_CHECK_DONE_I(coil_dn), .ADC_CAL_RUN_O(cal_run),
      .COIL_CHECK_RUN_O(coil_run), .STARTUP_DONE_O(st_dn));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] expv);
      n_tests++;
      if (seen !== expv) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, expv, seen);
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // read data is judged where the master takes it, against the oldest note
   always @(posedge mclk) begin
      if (req.read === 1'b1 && wreq === 1'b0) begin
         if (exp_q.size() == 0) check("unexpected read", 64'h1, 64'h0);
         else check("readdata", rdata, exp_q.pop_front());
      end
   end

   function automatic logic [15:0] mask_of(input logic [5:0] idx);
      case (idx)
         `ADCR_IDX_COEF2, `ADCR_IDX_COEF3, `ADCR_IDX_AKV_LO, `ADCR_IDX_DKV_LO: mask_of = `ADCR_MASK_FULL;
         `ADCR_IDX_AKV_HI, `ADCR_IDX_DKV_HI: mask_of = `ADCR_MASK_KV_HI;
         `ADCR_IDX_LPF: mask_of = `ADCR_MASK_LPF;
         `ADCR_IDX_CTRL: mask_of = `ADCR_MASK_CTRL;
         default: mask_of = 16'h0000;
      endcase
   endfunction

   // no release here, so consecutive calls run back to back
   task automatic bus(input logic rd, input logic [5:0] idx, input logic [3:0] be, input logic [31:0] wd);
      int n;
      req.read <= rd;
      req.write <= ~rd;
      req.address <= {idx, 2'b00};
      req.byteenable <= be;
      req.writedata <= wd;
      // waitrequest is judged as it stood just before the edge
      for (n = 0; n < 20; n++) begin
         @(posedge mclk);
         if (wreq === 1'b0) break;
      end
      if (n == 20) begin
         check("waitrequest timeout", 64'h1, 64'h0);
         test_done();
      end
   endtask

   task automatic wr(input logic [5:0] idx, input logic [3:0] be, input logic [15:0] d);
      logic [15:0] v;
      v = regs[idx];
      if (be[0]) v[7:0] = d[7:0];
      if (be[1]) v[15:8] = d[15:8];
      regs[idx] = v & mask_of(idx);
      bus(1'b0, idx, be, {16'hFFFF, d});
   endtask

   task automatic rd(input logic [5:0] idx);
      exp_q.push_back({16'h0000, regs[idx]});
      bus(1'b1, idx, 4'hF, 32'h0);
   endtask

   task automatic idle(input int n);
      req <= '0;
      repeat (n) @(posedge mclk);
   endtask

   task automatic reset();
      @(posedge mclk);
      rst <= 1'b1;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      regs = '{default: 16'h0000};
      rx_acc = 24'h0;
      vel_acc = 24'h0;
   endtask

   task automatic read_all();
      for (int i = 'h1C; i < 'h30; i++) rd(i[5:0]);
      rd(6'h00);
      rd(6'h3F);
      idle(2);
   endtask

   task automatic cfg_check();
      @(negedge mclk);
      check("coef2", cfg.coef2, regs[`ADCR_IDX_COEF2]);
      check("coef3", cfg.coef3, regs[`ADCR_IDX_COEF3]);
      check("abs_kv", cfg.abs_kv, {regs[`ADCR_IDX_AKV_HI][7:0], regs[`ADCR_IDX_AKV_LO]});
      check("delay_kv", cfg.delay_kv, {regs[`ADCR_IDX_DKV_HI][7:0], regs[`ADCR_IDX_DKV_LO]});
      check("ang_k", cfg.ang_k, 8'h10 << regs[`ADCR_IDX_LPF][5:4]);
      check("vel_k", cfg.vel_k, 8'h10 << regs[`ADCR_IDX_LPF][3:2]);
      check("ctrl bits", {cfg.ang_src, cfg.cal_dir, cfg.skip_cal, cfg.skip_coil},
            {regs[`ADCR_IDX_CTRL][5:4], regs[`ADCR_IDX_CTRL][2:0]});
      @(posedge mclk);
   endtask

   logic [5:0] idx_tab [8] = '{6'h20, 6'h21, 6'h22, 6'h23, 6'h26, 6'h27, 6'h2A, 6'h2B};

   initial begin
      logic [15:0] r;
      logic signed [32:0] sum;
      logic signed [40:0] e;
      logic signed [23:0] d;
      logic [1:0] m;
      adcr_pkg::adcr_start_state_type st;
      num_errors = 0;
      n_tests = 0;
      rst = 1'b1;
      req = '0;
      {f2, f3, vel, rx, a_d, a_l, a_a} = '0;
      {vel_v, rx_v, por, cal_dn, coil_dn} = '0;
      void'($urandom(32'h5EF9C318));
      reset();
      read_all();
      cfg_check();
      $display("test reset_values done");

      foreach (idx_tab[i]) wr(idx_tab[i], 4'h3, $urandom());
      foreach (idx_tab[i]) rd(idx_tab[i]);
      idle(0);
      cfg_check();
      foreach (idx_tab[i]) wr(idx_tab[i], 4'hF, 16'hFFFF);
      wr(6'h24, 4'h3, 16'hA5A5);
      wr(6'h2C, 4'h3, 16'hFFFF);
      wr(`ADCR_IDX_COEF2, 4'h1, 16'h1234);
      wr(`ADCR_IDX_COEF3, 4'h2, 16'h5678);
      read_all();
      cfg_check();
      reset();
      read_all();
      $display("test register_access done");

      for (int c = 0; c < 4; c++) begin
         wr(`ADCR_IDX_LPF, 4'h3, {10'h3FF, c[1:0], 2'(3 - c), 2'b11});
         idle(0);
         cfg_check();
         r = $urandom_range(16'h3FFF);
         rx <= (c[0]) ? -$signed(r) : $signed(r);
         vel <= $signed(r) >>> 1;
         rx_v <= 1'b1;
         vel_v <= 1'b1;
         @(posedge mclk);
         rx_v <= 1'b0;
         vel_v <= 1'b0;
         d = $signed({rx, 8'h00}) - rx_acc;
         rx_acc = rx_acc + (d >>> (4 + c));
         d = $signed({vel, 8'h00}) - vel_acc;
         vel_acc = vel_acc + (d >>> (7 - c));
         repeat (2) @(posedge mclk);
         @(negedge mclk);
         check("rx_lpf", rx_lpf, rx_acc[23:8]);
         check("vel_lpf", vel_lpf, vel_acc[23:8]);
         @(posedge mclk);
      end
      $display("test lowpass done");

      for (int c = 0; c < 4; c++) begin
         m = c[1:0];
         wr(`ADCR_IDX_CTRL, 4'h3, {10'h0, m, 1'b1, 3'($urandom())});
         idle(0);
         a_d <= $urandom();
         a_l <= $urandom();
         a_a <= $urandom();
         cfg_check();
         @(posedge mclk);
         @(negedge mclk);
         check("angle", ang, m[1] ? (m[0] ? a_a : a_l) : a_d);
         @(posedge mclk);
      end
      $display("test angle_mux done");

      for (int i = 0; i < 6; i++) begin
         for (int k = 0; k < 6; k++) begin
            r = $urandom();
            if (i == 0) r = 16'h80FF;
            if (i == 1) r = k[0] ? 16'hC000 : 16'h0000;
            if (i == 2 && k < 2) r = k[0] ? 16'h0000 : 16'h4000;
            wr(idx_tab[k], 4'h3, r);
         end
         idle(0);
         f2 <= (i == 0) ? 16'sh8000 : $urandom();
         f3 <= (i == 0) ? 16'sh8000 : $urandom();
         vel <= (i == 0) ? 16'sh8000 : (i == 1) ? 16'h0001 : (i == 2) ? 16'hFFFF : $urandom();
         repeat (2) @(posedge mclk);
         @(negedge mclk);
         sum = f2 * $signed(regs[`ADCR_IDX_COEF2]) + f3 * $signed(regs[`ADCR_IDX_COEF3]);
         check("clarke", clk_re, 19'(sum >>> `ADCR_Q_FRAC));
         e = vel * $signed({1'b0, regs[6'h22][7:0], regs[6'h23]});
         check("abs_term", akv_t, e);
         e = vel * $signed({1'b0, regs[6'h26][7:0], regs[6'h27]});
         check("delay_term", dkv_t, e);
         @(posedge mclk);
      end
      $display("test datapath done");

      for (int sc = 0; sc < 4; sc++) begin
         reset();
         wr(`ADCR_IDX_CTRL, 4'h3, {14'h0, sc[1:0]});
         idle(0);
         st = adcr_pkg::ST_IDLE;
         for (int s = 0; s < 3 && st != adcr_pkg::ST_DONE; s++) begin
            por <= (s == 0);
            cal_dn <= (st == adcr_pkg::ST_ADC_CAL);
            coil_dn <= (st == adcr_pkg::ST_COIL);
            if (st == adcr_pkg::ST_IDLE) st = sc[1] ? (sc[0] ? adcr_pkg::ST_DONE : adcr_pkg::ST_COIL)
                                                     : adcr_pkg::ST_ADC_CAL;
            else if (st == adcr_pkg::ST_ADC_CAL) st = sc[0] ? adcr_pkg::ST_DONE : adcr_pkg::ST_COIL;
            else st = adcr_pkg::ST_DONE;
            @(posedge mclk);
            {por, cal_dn, coil_dn} <= 3'b000;
            repeat (2) @(posedge mclk);
            @(negedge mclk);
            check("startup run", {cal_run, coil_run, st_dn},
                  {st == adcr_pkg::ST_ADC_CAL, st == adcr_pkg::ST_COIL, st == adcr_pkg::ST_DONE});
            regs[6'h2C] = {13'h0, st == adcr_pkg::ST_DONE, st};
            @(posedge mclk);
            rd(6'h2C);
            idle(0);
         end
      end
      $display("test startup done");
      idle(2);
      test_done();
   end
endmodule // tb
